/* File: hw/adc_seq_consts.vh */
// constants for the serial converter sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// control word fields
`define CW_WIDTH        16
`define CW_WRITE        15
`define CW_REPEAT       14
`define CW_AIN_TOP      13
`define CW_TEMP         5
`define CW_REF          2
`define CW_AVG          1
`define CW_STANDBY      0
`define CW_RESET        16'h0000

// channel scan set: bits 0..7 analog inputs, bit 8 temperature
`define NCH             9
`define CH_TEMP         4'h8
`define TAG_TEMP_PLAIN  4'h8
`define TAG_TEMP_AVG    4'h9
`define TAG_W           4
`define RES_W           12
`define WORD_ALL_ONES   16'hFFFF

// frame
`define FRAME_BITS      5'h10
`define CNT_W           5

// timing
`define CLK_NS          20
`define PD_MIN_NS       90
`define RST_MAX_NS      60
`define STBY_UP_NS      1000
`define BUSY_MAX_US     100
`define PD_MIN_CYC      ((`PD_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_MAX_CYC     (`RST_MAX_NS / `CLK_NS)
`define STBY_UP_CYC     ((`STBY_UP_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_MAX_CYC    ((`BUSY_MAX_US * 1000) / `CLK_NS)
`define TMR_W           14

// result buffer
`define FIFO_W          16
`define FIFO_DEPTH      32
`define FIFO_AW         5

`endif

/* File: hw/pin_sync.v */
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module pin_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire clk_i,
   input  wire rst_i,
   input  wire d_i,
   output reg  q_o
);
   reg meta_r;

   // first flop feeds only the second
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // pin_sync

/* File: hw/result_fifo.v */
// result buffer fifo with registered read data
`timescale 1ns/1ps
module result_fifo #(
   parameter W     = 16,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         flush_i,
   input  wire         in_valid_i,
   output reg          in_ready_o,
   input  wire [W-1:0] in_data_i,
   output reg          out_valid_o,
   input  wire         out_ready_i,
   output reg  [W-1:0] out_data_o
);
   reg  [W-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0] wptr_r;
   reg  [AW-1:0] rptr_r;
   reg  [AW:0]   count_r;
   wire          push;
   wire          pop;
   wire [AW-1:0] rptr_nxt;
   wire [AW:0]   count_nxt;

   assign push      = in_valid_i & in_ready_o;
   assign pop       = out_ready_i & out_valid_o;
   assign rptr_nxt  = pop ? rptr_r + 1'b1 : rptr_r;
   assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // storage array, no reset needed
   always @(posedge clk_i) begin
      if (push)
         mem[wptr_r] <= in_data_i;
   end

   // pointers, flags and show-ahead head word
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_r      <= {AW{1'b0}};
         rptr_r      <= {AW{1'b0}};
         count_r     <= {(AW+1){1'b0}};
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
         out_data_o  <= {W{1'b0}};
      end else if (flush_i) begin
         wptr_r      <= {AW{1'b0}};
         rptr_r      <= {AW{1'b0}};
         count_r     <= {(AW+1){1'b0}};
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push)
            wptr_r <= wptr_r + 1'b1;
         rptr_r      <= rptr_nxt;
         count_r     <= count_nxt;
         in_ready_o  <= (count_nxt != DEPTH);
         out_valid_o <= (count_nxt != 0);
         // bypass covers a word written into the head slot this cycle
         if (push && (wptr_r == rptr_nxt))
            out_data_o <= in_data_i;
         else
            out_data_o <= mem[rptr_nxt];
      end
   end
endmodule // result_fifo

/* File: hw/adc_sequencer_serial_control.v */
// serial frame control and channel sequencer of the eight-input converter
//
// Functional notes
// - control bit 5 adds temperature channel
// - control bit 2 selects external reference
// - bit 1 averaging, ignored unless bit 5
// - bit 0 one enters standby next
// - frame out is tag then result
// - tags 0-7 inputs, 8/9 temperature
// - chip-select fall drives tag msb
// - output released at 16th falling edge
// - busy rises at next chip-select fall
// - while busy later frames ignored, ones
// - temperature conversion ends within 100 us
// - standby in first busy write aborts
// - write, convert next, read after that
// - ascending one per frame then stop
// - all ones when finished or none
// - repeat wraps to lowest channel forever
// - valid write ends repeat operation
// - standby at rise, resets averaging, ones
// - standby exit powers up within 1 us
// - long pin low powers down, defaults
// - short pin low resets to defaults
// - medium pin low resets only
// - bit 15 gates control word update
// - early rise aborts, no update
// - bits 13..6 select inputs 0..7
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_sequencer_serial_control #(
   parameter BUSY_MAX_CYC = `BUSY_MAX_CYC,
   parameter PWRUP_CYC    = 50
) (
   input  wire                clk_i,
   input  wire                rst_i,
   input  wire                sclk_i,
   input  wire                cs_n_i,
   input  wire                din_i,
   input  wire                powerdown_reset_pin_n_i,
   output reg                 dout_o,
   output reg                 dout_oe_o,
   output reg                 temp_conversion_busy_o,
   output reg                 standby_o,
   output reg                 powerdown_o,
   output reg                 conv_start_o,
   output reg [`TAG_W-1:0]    conv_chan_o,
   output reg                 reference_source_select_o,
   output reg                 temp_averaging_enable_o,
   output reg                 avg_reset_o,
   output reg                 conv_abort_o,
   input  wire                conversion_result_valid_i,
   input  wire [`RES_W-1:0]   conversion_result_i,
   output wire                conversion_result_ready_o
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection

   wire sclk_s;
   wire cs_n_s;
   wire din_s;
   wire pdr_n_s;
   reg  sclk_d_r;
   reg  cs_n_d_r;

   pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (.clk_i(clk_i), .rst_i(rst_i), .d_i(sclk_i), .q_o(sclk_s));
   pin_sync #(.RST_VAL(1'b1)) u_sync_cs (.clk_i(clk_i), .rst_i(rst_i), .d_i(cs_n_i), .q_o(cs_n_s));
   pin_sync #(.RST_VAL(1'b0)) u_sync_din (.clk_i(clk_i), .rst_i(rst_i), .d_i(din_i), .q_o(din_s));
   pin_sync #(.RST_VAL(1'b1)) u_sync_pdr (.clk_i(clk_i), .rst_i(rst_i),
                                          .d_i(powerdown_reset_pin_n_i), .q_o(pdr_n_s));

   // edges are found on the second flop output only
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   wire sclk_fall = sclk_d_r & ~sclk_s;
   wire cs_fall   = cs_n_d_r & ~cs_n_s;
   wire cs_rise   = ~cs_n_d_r & cs_n_s;

   ////////////////////////////////////////////////////////////////////////
   // state

   reg [`CW_WIDTH-1:0]  ctrl_r;       // conversion_control_word
   reg [`NCH-1:0]       scan_r;       // channels still to convert
   reg [`CNT_W-1:0]     bit_cnt_r;
   reg [`CW_WIDTH-1:0]  shift_r;
   reg [`CW_WIDTH-1:0]  din_sr_r;
   reg                  in_frame_r;
   reg                  frame_ign_r;  // frame dropped while busy
   reg                  frame_conv_r; // frame carries a conversion
   reg                  honor_used_r; // busy frame already consumed
   reg [`TMR_W-1:0]     busy_cnt_r;
   reg [`TMR_W-1:0]     pwrup_cnt_r;
   reg [`TMR_W-1:0]     pd_low_cnt_r;
   reg [`TAG_W-1:0]     tag_hold_r;
   reg                  conv_live_r;

   wire [`FIFO_W-1:0]   fifo_out;
   wire                 fifo_out_valid;
   reg                  fifo_pop;
   reg                  fifo_flush;

   ////////////////////////////////////////////////////////////////////////
   // channel set decode and lowest-channel pick

   reg  [`NCH-1:0] sel_cur;
   reg  [`NCH-1:0] sel_new;
   reg  [`NCH-1:0] pick_src;
   reg  [`NCH-1:0] pick_rest;
   reg  [`TAG_W-1:0] pick_idx;
   reg             pick_any;
   reg  [`CW_WIDTH-1:0] word_in;
   integer k;

   // reload values sized to the timer so loads neither pad nor drop bits
   localparam [`TMR_W-1:0] PWRUP_LOAD = PWRUP_CYC;
   localparam [`TMR_W-1:0] STBY_LOAD  = `STBY_UP_CYC;

   always @* begin
      word_in = {din_sr_r[`CW_WIDTH-2:0], din_s};
      for (k = 0; k < `NCH - 1; k = k + 1) begin
         sel_cur[k] = ctrl_r[`CW_AIN_TOP - k];
         sel_new[k] = word_in[`CW_AIN_TOP - k];
      end
      sel_cur[`NCH-1] = ctrl_r[`CW_TEMP];
      sel_new[`NCH-1] = word_in[`CW_TEMP];
      if (scan_r == {`NCH{1'b0}} && ctrl_r[`CW_REPEAT])
         pick_src = sel_cur;
      else
         pick_src = scan_r;
      pick_any = 1'b0;
      pick_idx = {`TAG_W{1'b0}};
      for (k = `NCH - 1; k >= 0; k = k - 1) begin
         if (pick_src[k]) begin
            pick_any = 1'b1;
            pick_idx = k[`TAG_W-1:0];
         end
      end
      pick_rest = pick_src;
      if (pick_any)
         pick_rest[pick_idx] = 1'b0;
   end

   wire conv_allowed = ~standby_o & ~powerdown_o & (pwrup_cnt_r == {`TMR_W{1'b0}})
                       & ~temp_conversion_busy_o;

   ////////////////////////////////////////////////////////////////////////
   // result buffer between converter core and serial output

   wire res_in_valid = conversion_result_valid_i & conv_live_r;

   result_fifo #(
      .W     (`FIFO_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .flush_i     (fifo_flush),
      .in_valid_i  (res_in_valid),
      .in_ready_o  (conversion_result_ready_o),
      .in_data_i   ({tag_hold_r, conversion_result_i}),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out)
   );

   wire res_taken = res_in_valid & conversion_result_ready_o;

   ////////////////////////////////////////////////////////////////////////
   // main control process

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r                    <= `CW_RESET;
         scan_r                    <= {`NCH{1'b0}};
         bit_cnt_r                 <= {`CNT_W{1'b0}};
         shift_r                   <= `WORD_ALL_ONES;
         din_sr_r                  <= {`CW_WIDTH{1'b0}};
         in_frame_r                <= 1'b0;
         frame_ign_r               <= 1'b0;
         frame_conv_r              <= 1'b0;
         honor_used_r              <= 1'b0;
         busy_cnt_r                <= {`TMR_W{1'b0}};
         pwrup_cnt_r               <= {`TMR_W{1'b0}};
         pd_low_cnt_r              <= {`TMR_W{1'b0}};
         tag_hold_r                <= {`TAG_W{1'b0}};
         conv_live_r               <= 1'b0;
         fifo_pop                  <= 1'b0;
         fifo_flush                <= 1'b0;
         dout_o                    <= 1'b1;
         dout_oe_o                 <= 1'b0;
         temp_conversion_busy_o    <= 1'b0;
         standby_o                 <= 1'b0;
         powerdown_o               <= 1'b0;
         conv_start_o              <= 1'b0;
         conv_chan_o               <= {`TAG_W{1'b0}};
         reference_source_select_o <= 1'b0;
         temp_averaging_enable_o   <= 1'b0;
         avg_reset_o               <= 1'b0;
         conv_abort_o              <= 1'b0;
      end else if (!pdr_n_s) begin
         ctrl_r                    <= `CW_RESET;
         scan_r                    <= {`NCH{1'b0}};
         in_frame_r                <= 1'b0;
         dout_oe_o                 <= 1'b0;
         dout_o                    <= 1'b1;
         temp_conversion_busy_o    <= 1'b0;
         standby_o                 <= 1'b0;
         reference_source_select_o <= 1'b0;
         temp_averaging_enable_o   <= 1'b0;
         avg_reset_o               <= 1'b1;
         conv_abort_o              <= conv_live_r;
         conv_live_r               <= 1'b0;
         conv_start_o              <= 1'b0;
         fifo_pop                  <= 1'b0;
         fifo_flush                <= 1'b1;
         pwrup_cnt_r               <= {`TMR_W{1'b0}};
         if (pd_low_cnt_r != {`TMR_W{1'b1}})
            pd_low_cnt_r <= pd_low_cnt_r + 1'b1;
         // count reaches the minimum on the cycle the pin has been low that long
         if (pd_low_cnt_r >= `PD_MIN_CYC - 1)
            powerdown_o <= 1'b1;
      end else begin
         // single-cycle strobes default low
         fifo_pop     <= 1'b0;
         fifo_flush   <= 1'b0;
         conv_start_o <= 1'b0;
         avg_reset_o  <= 1'b0;
         conv_abort_o <= 1'b0;
         pd_low_cnt_r <= {`TMR_W{1'b0}};

         if (powerdown_o) begin
            powerdown_o <= 1'b0;
            pwrup_cnt_r <= PWRUP_LOAD;
         end else if (pwrup_cnt_r != {`TMR_W{1'b0}}) begin
            pwrup_cnt_r <= pwrup_cnt_r - 1'b1;
         end

         if (temp_conversion_busy_o) begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
            if (res_taken || busy_cnt_r >= BUSY_MAX_CYC - 1) begin
               temp_conversion_busy_o <= 1'b0;
               honor_used_r           <= 1'b0;
            end
         end
         if (res_taken)
            conv_live_r <= 1'b0;

         // frame start
         if (cs_fall) begin
            in_frame_r   <= 1'b1;
            bit_cnt_r    <= {`CNT_W{1'b0}};
            frame_conv_r <= 1'b0;
            dout_oe_o    <= 1'b1;
            if (temp_conversion_busy_o && honor_used_r) begin
               frame_ign_r <= 1'b1;
               shift_r     <= `WORD_ALL_ONES;
               dout_o      <= 1'b1;
            end else begin
               frame_ign_r <= 1'b0;
               if (fifo_out_valid && !standby_o) begin
                  shift_r  <= fifo_out;
                  dout_o   <= fifo_out[`CW_WIDTH-1];
                  fifo_pop <= 1'b1;
               end else begin
                  shift_r <= `WORD_ALL_ONES;
                  dout_o  <= 1'b1;
               end
               if (conv_allowed && pick_any) begin
                  scan_r       <= pick_rest;
                  frame_conv_r <= 1'b1;
                  conv_start_o <= 1'b1;
                  conv_live_r  <= 1'b1;
                  reference_source_select_o <= ctrl_r[`CW_REF];
                  if (pick_idx == `CH_TEMP) begin
                     conv_chan_o <= ctrl_r[`CW_AVG] ? `TAG_TEMP_AVG : `TAG_TEMP_PLAIN;
                     tag_hold_r  <= ctrl_r[`CW_AVG] ? `TAG_TEMP_AVG : `TAG_TEMP_PLAIN;
                     temp_conversion_busy_o <= 1'b1;
                     busy_cnt_r             <= {`TMR_W{1'b0}};
                  end else begin
                     conv_chan_o <= pick_idx;
                     tag_hold_r  <= pick_idx;
                  end
               end
            end
         end else if (in_frame_r && sclk_fall && bit_cnt_r != `FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            din_sr_r  <= word_in;
            if (bit_cnt_r == `FRAME_BITS - 1'b1) begin
               dout_oe_o <= 1'b0;
               // standby in first busy write aborts
               if (temp_conversion_busy_o && !frame_ign_r && word_in[`CW_WRITE]
                   && word_in[`CW_STANDBY]) begin
                  temp_conversion_busy_o <= 1'b0;
                  honor_used_r           <= 1'b0;
                  conv_abort_o           <= 1'b1;
                  conv_live_r            <= 1'b0;
                  standby_o              <= 1'b1;
                  avg_reset_o            <= 1'b1;
               end
            end else begin
               shift_r <= {shift_r[`CW_WIDTH-2:0], 1'b1};
               dout_o  <= shift_r[`CW_WIDTH-2];
            end
         end else if (cs_rise && in_frame_r) begin
            in_frame_r <= 1'b0;
            dout_oe_o  <= 1'b0;
            if (!frame_ign_r && temp_conversion_busy_o)
               honor_used_r <= 1'b1;
            if (bit_cnt_r != `FRAME_BITS) begin
               if (frame_conv_r && conv_live_r) begin
                  conv_abort_o <= 1'b1;
                  conv_live_r  <= 1'b0;
                  if (temp_conversion_busy_o) begin
                     temp_conversion_busy_o <= 1'b0;
                     honor_used_r           <= 1'b0;
                  end
               end
            end else if (!frame_ign_r && din_sr_r[`CW_WRITE]) begin
               ctrl_r <= din_sr_r;
               scan_r <= sel_word(din_sr_r);
               temp_averaging_enable_o <= din_sr_r[`CW_AVG] & din_sr_r[`CW_TEMP];
               if (din_sr_r[`CW_STANDBY] && !standby_o) begin
                  standby_o   <= 1'b1;
                  avg_reset_o <= 1'b1;
                  fifo_flush  <= 1'b1;
               end else if (!din_sr_r[`CW_STANDBY] && standby_o) begin
                  standby_o   <= 1'b0;
                  pwrup_cnt_r <= STBY_LOAD;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel set of a freshly written word

   function [`NCH-1:0] sel_word;
      input [`CW_WIDTH-1:0] w;
      integer j;
      begin
         for (j = 0; j < `NCH - 1; j = j + 1)
            sel_word[j] = w[`CW_AIN_TOP - j];
         sel_word[`NCH-1] = w[`CW_TEMP];
      end
   endfunction

endmodule // adc_sequencer_serial_control

/* File: tb/adc_seq_sva.sv */
// assertion checker for the serial converter sequencer
`timescale 1ns/1ps
module adc_seq_sva #(
   parameter BUSY_MAX_CYC = 5000,
   parameter PWRUP_CYC    = 50
) (
   input wire       clk_i,
   input wire       rst_i,
   input wire       cs_n_i,
   input wire       powerdown_reset_pin_n_i,
   input wire       dout_o,
   input wire       dout_oe_o,
   input wire       temp_conversion_busy_o,
   input wire       standby_o,
   input wire       powerdown_o,
   input wire       conv_start_o,
   input wire [3:0] conv_chan_o,
   input wire       temp_averaging_enable_o,
   input wire       avg_reset_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   reg [15:0] busy_cnt_r;
   // length of the current busy stretch, zero while idle
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         busy_cnt_r <= 16'h0000;
      else
         busy_cnt_r <= temp_conversion_busy_o ? busy_cnt_r + 16'h0001 : 16'h0000;
   end
   sequence cs_fall_s;
      $fell(cs_n_i) ##0 (powerdown_reset_pin_n_i && !powerdown_o);
   endsequence
   sequence pin_low_s;
      !powerdown_reset_pin_n_i [*4];
   endsequence
   chk_oe_on: assert property (cs_fall_s |-> ##[1:5] dout_oe_o)
      else $error("output not driven after select fall");
   chk_oe_off: assert property (cs_n_i [*6] |-> !dout_oe_o)
      else $error("output still driven outside frame");
   chk_start_frame: assert property (conv_start_o |-> !cs_n_i)
      else $error("conversion started outside frame");
   chk_tag_legal: assert property (conv_start_o |-> conv_chan_o <= 4'h9)
      else $error("illegal channel tag");
   chk_tag_avg: assert property (conv_start_o && conv_chan_o == 4'h9 |-> temp_averaging_enable_o)
      else $error("averaged tag without averaging");
   chk_busy_start: assert property (conv_start_o && conv_chan_o[3] |-> ##[0:1] temp_conversion_busy_o)
      else $error("busy missing for temperature");
   chk_busy_max: assert property (busy_cnt_r <= BUSY_MAX_CYC + 2)
      else $error("busy held too long");
   chk_pd_enter: assert property (!powerdown_reset_pin_n_i [*8] |=> powerdown_o)
      else $error("long pin low gave no power-down");
   chk_pd_exit: assert property (powerdown_reset_pin_n_i [*5] |-> !powerdown_o)
      else $error("power-down held with pin high");
   chk_pin_reset: assert property (pin_low_s |=> avg_reset_o && !temp_averaging_enable_o && !standby_o)
      else $error("pin low did not reset state");
   chk_stby_ones: assert property (standby_o && dout_oe_o |-> dout_o)
      else $error("standby read not all ones");
endmodule // adc_seq_sva
////////////////////////////////////////////////////////////////////////////////
bind adc_sequencer_serial_control adc_seq_sva #(.BUSY_MAX_CYC(BUSY_MAX_CYC), .PWRUP_CYC(PWRUP_CYC))
   adc_seq_sva_i (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .powerdown_reset_pin_n_i(powerdown_reset_pin_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
   .temp_conversion_busy_o(temp_conversion_busy_o), .standby_o(standby_o), .powerdown_o(powerdown_o),
   .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
   .temp_averaging_enable_o(temp_averaging_enable_o), .avg_reset_o(avg_reset_o));

/* File: tb/host_port.sv */
// host serial port model driving frames of n clocks, 16 for a full word
`timescale 1ns/1ps
module host_port (
   input  wire clk_i,
   input  wire dout_i,
   input  wire dout_oe_i,
   output reg  sclk_o,
   output reg  cs_n_o,
   output reg  din_o
);
   // released line shows the inverse, never a stale copy
   wire line_w = dout_oe_i ? dout_i : ~dout_i;
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   // link clock 160 ns, still between frames
   task xfer(input [15:0] w, input integer n, output [15:0] r);
      integer i;
      begin
         r = 16'h0000;
         cs_n_o = 1'b0;
         din_o = w[15];
         repeat (8) @(negedge clk_i);
         for (i = 0; i < n; i = i + 1) begin
            r = {r[14:0], line_w};
            sclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            din_o = (i < 15) ? w[(14 - i) & 15] : ~din_o;
            repeat (4) @(negedge clk_i);
         end
         cs_n_o = 1'b1;
         din_o = ~din_o;
         // idle gap before next select fall
         repeat (12) @(negedge clk_i);
      end
   endtask
endmodule // host_port

/* File: tb/tb_top.sv */
// self-checking bench for the serial converter sequencer
`timescale 1ns/1ps
module tb_top;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         pin_n = 1'b1;
   reg         res_v = 1'b0;
   reg  [11:0] res_d = 12'h000;
   reg  [15:0] rd;
   wire        sclk, cs_n, din, dout, dout_oe, busy, stby, pd, start, avg, avg_rst, ready;
   wire [3:0]  chan;
   wire        refsel;
   integer     bad_count = 0;
   integer     samples_checked = 0;
   integer     cyc = 0;
   always #10 clk_i = ~clk_i;
   adc_sequencer_serial_control #(.BUSY_MAX_CYC(50), .PWRUP_CYC(5)) adc_sequencer_serial_control_i (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .powerdown_reset_pin_n_i(pin_n), .dout_o(dout), .dout_oe_o(dout_oe),
      .temp_conversion_busy_o(busy), .standby_o(stby), .powerdown_o(pd), .conv_start_o(start),
      .conv_chan_o(chan), .reference_source_select_o(refsel), .temp_averaging_enable_o(avg),
      .avg_reset_o(avg_rst), .conv_abort_o(), .conversion_result_valid_i(res_v),
      .conversion_result_i(res_d), .conversion_result_ready_o(ready));
   host_port host_port_i (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk),
      .cs_n_o(cs_n), .din_o(din));
   // converter core: tagged code per start, held until taken
   always @(negedge clk_i) begin
      if (start) begin
         res_v <= 1'b1;
         res_d <= {chan, 8'h5A};
      end else if (ready)
         res_v <= 1'b0;
   end
   // hang guard, well above the few thousand cycles needed
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      begin
         if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task cmp16(input [8*12-1:0] nm, input [15:0] e, input [15:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task cmp1(input [8*12-1:0] nm, input e, input g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0s expected %b seen %b", nm, e, g);
         end
      end
   endtask
   task frx(input [15:0] w, input [15:0] e);
      begin
         host_port_i.xfer(w, 16, rd);
         cmp16("dout_word", e, rd);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      frx(16'h0000, 16'hFFFF);
      // one-shot scan of inputs one and three; later words keep write low
      host_port_i.xfer(16'h9400, 16, rd);
      host_port_i.xfer(16'h0000, 16, rd);
      frx(16'h0000, 16'h115A);
      frx(16'h0000, 16'h335A);
      frx(16'h0000, 16'hFFFF);
      // repeating scan: input seven, then averaged temperature
      host_port_i.xfer(16'hC062, 16, rd);
      cmp1("avg_enable", 1'b1, avg);
      host_port_i.xfer(16'h0000, 16, rd);
      frx(16'h0000, 16'h775A);
      frx(16'h0000, 16'h995A);
      frx(16'h0000, 16'h775A);
      // a fresh write leaves the loop after one pending result
      host_port_i.xfer(16'h8000, 16, rd);
      frx(16'h0000, 16'h775A);
      frx(16'h0000, 16'hFFFF);
      host_port_i.xfer(16'h8002, 16, rd);
      cmp1("avg_enable", 1'b0, avg);
      // standby, a cut-short exit frame, then the full exit
      host_port_i.xfer(16'h8001, 16, rd);
      cmp1("standby", 1'b1, stby);
      frx(16'h0000, 16'hFFFF);
      host_port_i.xfer(16'h8000, 9, rd);
      cmp1("standby", 1'b1, stby);
      host_port_i.xfer(16'h8000, 16, rd);
      cmp1("standby", 1'b0, stby);
      host_port_i.xfer(16'h8804, 16, rd);
      host_port_i.xfer(16'h0000, 16, rd);
      cmp1("ref_select", 1'b1, refsel);
      frx(16'h0000, 16'h225A);
      // short pin pulse drops the pending temperature selection
      host_port_i.xfer(16'h8022, 16, rd);
      pin_n = 1'b0;
      repeat (2) @(negedge clk_i);
      pin_n = 1'b1;
      repeat (6) @(negedge clk_i);
      cmp1("avg_enable", 1'b0, avg);
      cmp1("powerdown", 1'b0, pd);
      frx(16'h0000, 16'hFFFF);
      frx(16'h0000, 16'hFFFF);
      // long pin low powers down until released
      pin_n = 1'b0;
      repeat (10) @(negedge clk_i);
      cmp1("powerdown", 1'b1, pd);
      pin_n = 1'b1;
      repeat (11) @(negedge clk_i);
      cmp1("powerdown", 1'b0, pd);
      frx(16'h0000, 16'hFFFF);
      print_verdict;
   end
endmodule // tb_top
